// *** hdl/scs_pkg.sv ***
// Package with the offsets, field positions, reset values and types of the stepper configuration and status block.
package scs_pkg;
   localparam logic [7:0] ADDR_LIVE_FAULT = 8'h04;
   localparam logic [7:0] ADDR_X_OVERCURRENT = 8'h05;
   localparam logic [7:0] ADDR_Y_OVERCURRENT = 8'h06;
   localparam logic [7:0] ADDR_STEP_POSITION = 8'h07;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int PARITY_BIT = 7;
   localparam int THERMAL_WARNING_BIT = 6;
   localparam int CHARGE_PUMP_BIT = 5;
   localparam int OPEN_X_BIT = 3;
   localparam int OPEN_Y_BIT = 2;
   localparam int OVERCURRENT_MSB = 6;
   localparam int OVERCURRENT_LSB = 3;
   localparam int THERMAL_SHUTDOWN_BIT = 2;
   localparam logic [4:0] CURRENT_RESET = 5'h00;
   localparam logic [1:0] SLOPE_RESET = 2'h0;
   localparam logic [9:0] CURRENT_MIN_MA = 10'h00f;
   localparam logic [9:0] CURRENT_MAX_MA = 10'h320;

   typedef enum logic [2:0] {
      STEP_1_32 = 3'b000,
      STEP_1_16 = 3'b001,
      STEP_1_8 = 3'b010,
      STEP_1_4 = 3'b011,
      STEP_HALF_UNCOMP = 3'b100,
      STEP_HALF_COMP = 3'b101,
      STEP_FULL = 3'b110,
      STEP_RESERVED = 3'b111
   } scs_step_type;

   // Per-bridge transistor order: positive top, positive bottom, negative top, negative bottom.
   typedef struct packed {
      logic pos_top;
      logic pos_bottom;
      logic neg_top;
      logic neg_bottom;
   } scs_bridge_type;

   typedef struct packed {
      logic thermal_warning_flag;
      logic charge_pump_fail;
      logic open_coil_x_flag;
      logic open_coil_y_flag;
      scs_bridge_type x_bridge;
      scs_bridge_type y_bridge;
      logic thermal_shutdown_flag;
   } scs_fault_type;

   typedef struct packed {
      logic [4:0] peak_current_select;
      logic [1:0] edge_slope_select;
      scs_step_type step_resolution_select;
   } scs_config_type;
endpackage : scs_pkg

// *** hdl/scs_regs.sv ***
// Configuration decode and read-only status registers of the stepper driver.
//
// Behaviour
// - Five-bit peak current code maps monotonically from 15 mA to 800 mA.
// - Two-bit slope code gives 150, 100, 50 or 25 V per microsecond.
// - Step code selects 1/32..1/4, half uncompensated, half compensated, full; 111 reserved.
// - Four status registers are read only; the latched 05h and 06h clear to zero at reset.
// - Register 04h: parity, thermal warning, charge pump, open X, open Y.
// - Registers 04h and 07h show live values; 07h holds micro-step position.
// - Register 05h: parity and latched X bridge over-current flags in bits 6..3.
// - Register 06h: parity, latched Y over-current bits 6..3, latched thermal shutdown bit 2.
`timescale 1ns/1ps
`default_nettype none
module scs_regs (
   input wire logic I_REF_CLK,
   input wire logic I_ARST_N,
   input wire logic I_CFG_WR,
   input wire scs_pkg::scs_config_type I_CFG_DATA,
   input wire logic I_RD_EN,
   input wire logic [7:0] I_RD_ADDR,
   input wire scs_pkg::scs_fault_type I_FAULT,
   input wire logic [6:0] I_STEP_POSITION,
   output logic [7:0] O_RD_DATA,
   output logic O_RD_VALID,
   output scs_pkg::scs_config_type O_CFG,
   output logic [9:0] O_COIL_CURRENT_PEAK_MA,
   output logic [7:0] O_SLOPE_V_PER_US,
   output logic [5:0] O_MICROSTEPS_PER_FULL,
   output logic O_STEP_RESERVED
);
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   function automatic logic [9:0] current_ma(input logic [4:0] code);
      logic [9:0] ma;
      ma = scs_pkg::CURRENT_MIN_MA;
      case (code)
         5'h00: ma = 10'd15;
         5'h01: ma = 10'd30;
         5'h02: ma = 10'd45;
         5'h03: ma = 10'd50;
         5'h04: ma = 10'd55;
         5'h05: ma = 10'd61;
         5'h06: ma = 10'd67;
         5'h07: ma = 10'd74;
         5'h08: ma = 10'd82;
         5'h09: ma = 10'd91;
         5'h0a: ma = 10'd100;
         5'h0b: ma = 10'd110;
         5'h0c: ma = 10'd122;
         5'h0d: ma = 10'd135;
         5'h0e: ma = 10'd149;
         5'h0f: ma = 10'd164;
         5'h10: ma = 10'd181;
         5'h11: ma = 10'd200;
         5'h12: ma = 10'd221;
         5'h13: ma = 10'd244;
         5'h14: ma = 10'd269;
         5'h15: ma = 10'd297;
         5'h16: ma = 10'd328;
         5'h17: ma = 10'd362;
         5'h18: ma = 10'd400;
         5'h19: ma = 10'd441;
         5'h1a: ma = 10'd487;
         5'h1b: ma = 10'd538;
         5'h1c: ma = 10'd594;
         5'h1d: ma = 10'd656;
         5'h1e: ma = 10'd724;
         default: ma = scs_pkg::CURRENT_MAX_MA;
      endcase
      return ma;
   endfunction : current_ma

   // Even parity over the whole byte: bit 7 makes the count of ones even.
   function automatic logic [7:0] with_parity(input logic [6:0] body);
      return {^body, body};
   endfunction : with_parity

   // Configuration group.
   scs_pkg::scs_config_type next_cfg;
   logic [9:0] next_peak_ma;
   logic [7:0] next_slope;
   logic [5:0] next_usteps;
   logic next_reserved;

   always_comb begin
      next_cfg = I_CFG_WR ? I_CFG_DATA : O_CFG;
      next_peak_ma = current_ma(next_cfg.peak_current_select);
      case (next_cfg.edge_slope_select)
         2'h0: next_slope = 8'd150;
         2'h1: next_slope = 8'd100;
         2'h2: next_slope = 8'd50;
         default: next_slope = 8'd25;
      endcase
      next_reserved = 1'b0;
      case (next_cfg.step_resolution_select)
         scs_pkg::STEP_1_32: next_usteps = 6'd32;
         scs_pkg::STEP_1_16: next_usteps = 6'd16;
         scs_pkg::STEP_1_8: next_usteps = 6'd8;
         scs_pkg::STEP_1_4: next_usteps = 6'd4;
         scs_pkg::STEP_HALF_UNCOMP: next_usteps = 6'd2;
         scs_pkg::STEP_HALF_COMP: next_usteps = 6'd2;
         scs_pkg::STEP_FULL: next_usteps = 6'd1;
         default: begin
            next_usteps = 6'd0;
            next_reserved = 1'b1;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_CFG <= '{scs_pkg::CURRENT_RESET, scs_pkg::SLOPE_RESET, scs_pkg::STEP_1_32};
         O_COIL_CURRENT_PEAK_MA <= scs_pkg::CURRENT_MIN_MA;
         O_SLOPE_V_PER_US <= 8'd150;
         O_MICROSTEPS_PER_FULL <= 6'd32;
         O_STEP_RESERVED <= 1'b0;
      end else begin
         O_CFG <= next_cfg;
         O_COIL_CURRENT_PEAK_MA <= next_peak_ma;
         O_SLOPE_V_PER_US <= next_slope;
         O_MICROSTEPS_PER_FULL <= next_usteps;
         O_STEP_RESERVED <= next_reserved;
      end
   end

   // Status group. There is no write path into it at all.
   scs_pkg::scs_bridge_type x_latched;
   scs_pkg::scs_bridge_type y_latched;
   logic tsd_latched;
   scs_pkg::scs_bridge_type next_x_latched;
   scs_pkg::scs_bridge_type next_y_latched;
   logic next_tsd_latched;
   logic [7:0] next_rd_data;
   logic rd_x;
   logic rd_y;

   always_comb begin
      rd_x = I_RD_EN && (I_RD_ADDR == scs_pkg::ADDR_X_OVERCURRENT);
      rd_y = I_RD_EN && (I_RD_ADDR == scs_pkg::ADDR_Y_OVERCURRENT);
      // A new fault in the read cycle is kept, as the set term wins over the clear.
      next_x_latched = (rd_x ? 4'h0 : x_latched) | I_FAULT.x_bridge;
      next_y_latched = (rd_y ? 4'h0 : y_latched) | I_FAULT.y_bridge;
      next_tsd_latched = (rd_y ? 1'b0 : tsd_latched) | I_FAULT.thermal_shutdown_flag;
      next_rd_data = O_RD_DATA;
      case (I_RD_ADDR)
         scs_pkg::ADDR_LIVE_FAULT: next_rd_data = with_parity({I_FAULT.thermal_warning_flag,
            I_FAULT.charge_pump_fail, 1'b0, I_FAULT.open_coil_x_flag, I_FAULT.open_coil_y_flag,
            2'b00});
         scs_pkg::ADDR_X_OVERCURRENT: next_rd_data = with_parity({x_latched, 3'b000});
         scs_pkg::ADDR_Y_OVERCURRENT: next_rd_data = with_parity({y_latched, tsd_latched, 2'b00});
         scs_pkg::ADDR_STEP_POSITION: next_rd_data = with_parity(I_STEP_POSITION);
         default: next_rd_data = scs_pkg::STATUS_RESET;
      endcase
      if (!I_RD_EN) begin
         next_rd_data = O_RD_DATA;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         x_latched <= '0;
         y_latched <= '0;
         tsd_latched <= 1'b0;
         O_RD_DATA <= scs_pkg::STATUS_RESET;
         O_RD_VALID <= 1'b0;
      end else begin
         x_latched <= next_x_latched;
         y_latched <= next_y_latched;
         tsd_latched <= next_tsd_latched;
         O_RD_DATA <= next_rd_data;
         O_RD_VALID <= I_RD_EN;
      end
   end

   sequence read_of(logic [7:0] addr);
      I_RD_EN && I_RD_ADDR == addr;
   endsequence

   reset_clears_status_a: assert property (@(posedge I_REF_CLK)
      $rose(rst_n) |-> x_latched == 4'h0 && y_latched == 4'h0 && !tsd_latched && O_RD_DATA == 8'h00)
      else $error("status not zero after reset");
   read_parity_even_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      O_RD_VALID |-> ^O_RD_DATA == 1'b0)
      else $error("read data parity is odd");
   live_fault_read_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      read_of(scs_pkg::ADDR_LIVE_FAULT) |=> O_RD_DATA[6:5] == $past({I_FAULT.thermal_warning_flag,
      I_FAULT.charge_pump_fail}) && O_RD_DATA[3:2] == $past({I_FAULT.open_coil_x_flag,
      I_FAULT.open_coil_y_flag}) && O_RD_DATA[4] == 1'b0 && O_RD_DATA[1:0] == 2'b00)
      else $error("live fault register mismatch");
   step_position_read_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      read_of(scs_pkg::ADDR_STEP_POSITION) |=> O_RD_DATA[6:0] == $past(I_STEP_POSITION))
      else $error("step position register mismatch");
   x_flag_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      x_latched.pos_top && !rd_x |=> x_latched.pos_top)
      else $error("x flag dropped without a read");
   x_read_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      read_of(scs_pkg::ADDR_X_OVERCURRENT) ##0 I_FAULT.x_bridge == 4'h0 |=>
      x_latched == 4'h0 && O_RD_DATA[6:3] == $past(x_latched))
      else $error("x read did not clear or report");
   y_tsd_latch_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      I_FAULT.thermal_shutdown_flag ##1 read_of(scs_pkg::ADDR_Y_OVERCURRENT) |=> O_RD_DATA[2])
      else $error("thermal shutdown not latched");
   current_ends_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      (O_CFG.peak_current_select == 5'h1f |-> O_COIL_CURRENT_PEAK_MA == 10'd800) and
      (O_CFG.peak_current_select == 5'h00 |-> O_COIL_CURRENT_PEAK_MA == 10'd15))
      else $error("peak current decode wrong");
   slope_decode_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      O_CFG.edge_slope_select == 2'h3 |-> O_SLOPE_V_PER_US == 8'd25)
      else $error("slope decode wrong");
   step_decode_a: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
      (O_STEP_RESERVED == (O_CFG.step_resolution_select == scs_pkg::STEP_RESERVED)) and
      (O_CFG.step_resolution_select == scs_pkg::STEP_1_32 |-> O_MICROSTEPS_PER_FULL == 6'd32))
      else $error("step mode decode wrong");
endmodule : scs_regs
`default_nettype wire

// *** dv/scs_host_model.sv ***
// Host controller model that drives the configuration and status read ports.
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rd_data,
   input wire logic i_rd_valid,
   output logic o_cfg_wr,
   output scs_pkg::scs_config_type o_cfg_data,
   output logic o_rd_en,
   output logic [7:0] o_rd_addr
);
   initial begin
      o_cfg_wr = 1'b0;
      o_cfg_data = '0;
      o_rd_en = 1'b0;
      o_rd_addr = 8'h00;
   end

   // Status registers are only ever read; the host has no way to write them.
   task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
      @(posedge i_clk);
      #1;
      o_rd_en = 1'b1;
      o_rd_addr = addr;
      @(posedge i_clk);
      #1;
      o_rd_en = 1'b0;
      o_rd_addr = ~addr;
      data = i_rd_data;
      valid = i_rd_valid;
   endtask : rd

   task automatic wr(input scs_pkg::scs_config_type cfg);
      @(posedge i_clk);
      #1;
      o_cfg_wr = 1'b1;
      o_cfg_data = cfg;
      @(posedge i_clk);
      #1;
      o_cfg_wr = 1'b0;
      o_cfg_data = ~cfg;
   endtask : wr
endmodule : scs_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the stepper configuration and status registers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk;
   logic arst_n;
   logic cfg_wr;
   scs_pkg::scs_config_type cfg_data;
   logic rd_en;
   logic [7:0] rd_addr;
   scs_pkg::scs_fault_type fault;
   logic [6:0] step_pos;
   logic [7:0] rd_data;
   logic rd_valid;
   scs_pkg::scs_config_type cfg;
   logic [9:0] peak_ma;
   logic [7:0] slope;
   logic [5:0] usteps;
   logic step_rsv;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] got;
   logic vld;
   logic [4:0] cur_code [8] = '{5'h00, 5'h03, 5'h0a, 5'h10, 5'h18, 5'h1a, 5'h1e, 5'h1f};
   logic [9:0] cur_ma [8] = '{10'h00f, 10'h032, 10'h064, 10'h0b5, 10'h190, 10'h1e7, 10'h2d4, 10'h320};
   logic [7:0] slope_v [4] = '{8'h96, 8'h64, 8'h32, 8'h19};
   logic [5:0] ustep_v [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h00};

   scs_regs u_scs_regs (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_CFG_WR(cfg_wr), .I_CFG_DATA(cfg_data),
      .I_RD_EN(rd_en), .I_RD_ADDR(rd_addr), .I_FAULT(fault), .I_STEP_POSITION(step_pos),
      .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_CFG(cfg), .O_COIL_CURRENT_PEAK_MA(peak_ma),
      .O_SLOPE_V_PER_US(slope), .O_MICROSTEPS_PER_FULL(usteps), .O_STEP_RESERVED(step_rsv));

   scs_host_model u_scs_host_model (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
      .o_cfg_wr(cfg_wr), .o_cfg_data(cfg_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
      compares++;
      if (got_v !== exp_v) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask : check

   // Reads one status byte and expects the body with even parity in bit 7.
   task automatic rd_chk(input logic [7:0] addr, input logic [6:0] body);
      u_scs_host_model.rd(addr, got, vld);
      check({8'h00, got}, {8'h00, ^body, body});
      check({15'h0000, vld}, 16'h0001);
   endtask : rd_chk

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      arst_n = 1'b0;
      fault = '0;
      step_pos = 7'h00;
      repeat (10) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check({6'h00, peak_ma}, 16'h000f);
      check({8'h00, slope}, 16'h0096);
      check({10'h000, usteps}, 16'h0020);
      for (int a = 4; a < 9; a++) rd_chk(a[7:0], 7'h00);
      for (int i = 0; i < 8; i++) begin
         u_scs_host_model.wr({cur_code[i], i[1:0], i[2:0]});
         check({6'h00, cfg}, {6'h00, cur_code[i], i[1:0], i[2:0]});
         check({6'h00, peak_ma}, {6'h00, cur_ma[i]});
         check({8'h00, slope}, {8'h00, slope_v[i % 4]});
         check({10'h000, usteps}, {10'h000, ustep_v[i]});
         check({15'h0000, step_rsv}, {15'h0000, i == 7});
      end
      fault.thermal_warning_flag = 1'b1;
      fault.open_coil_x_flag = 1'b1;
      rd_chk(8'h04, 7'b1001000);
      fault = '0;
      fault.charge_pump_fail = 1'b1;
      fault.open_coil_y_flag = 1'b1;
      rd_chk(8'h04, 7'b0100100);
      fault = '0;
      step_pos = 7'h55;
      rd_chk(8'h07, 7'h55);
      step_pos = 7'h2a;
      rd_chk(8'h07, 7'h2a);
      fault.x_bridge = 4'b1010;
      @(posedge clk);
      #1;
      fault = '0;
      rd_chk(8'h05, 7'b1010000);
      rd_chk(8'h05, 7'h00);
      fault.y_bridge = 4'b0101;
      fault.thermal_shutdown_flag = 1'b1;
      rd_chk(8'h06, 7'b0101100);
      rd_chk(8'h06, 7'b0101100);
      fault = '0;
      rd_chk(8'h06, 7'b0101100);
      rd_chk(8'h06, 7'h00);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
